// [verilog/fcs_clock_source.sv]
// Clock source selector: mode sequencing, dividers, source switching and AXI4-Lite registers
// Behaviour
// - Seven modes: two engaged, two bypassed, two bypassed low power, and stop.
// - Reset leaves the block in engaged internal mode with no software action.
// - Engaged internal: output from loop on internal reference; debug clock from loop.
// - Engaged external: output from loop on external reference; debug clock from loop.
// - Bypassed internal: loop runs, output from internal reference; debug clock from loop.
// - Bypassed internal low power: loop off, output internal reference, no debug clock.
// - Bypassed external: loop runs, output from external reference; debug clock from loop.
// - Bypassed external low power: loop off, output external reference, no debug clock.
// - Stop: loop off, no system or debug clock, references per stop enables.
// - Selected source passes a bus divider of 1, 2, 4 or 8.
// - Bus clock runs at half the divided module output rate.
// - Debug clock is the loop oscillator divided by two when available.
// - Source select codes: loop, internal, external; reserved code acts as loop.
// - Reference divider divides the loop reference by two to the field, reset 1.
// - Reference select set feeds the loop from internal, clear from external.
// - Internal reference output enable gates the internal reference clock output.
// - Stop enable keeps internal reference running in stop if enabled or used.
// - Internal reference trimmed by eight coarse bits plus one fine bit.
// - Drives crystal oscillator gain, range, request, enable and stop enable.
// - Bus divider resets to divide by two.
// - Reference status follows the select only after synchronisation.
`timescale 1ns/1ps
`default_nettype none

module fcs_clock_source #(
   parameter int ADDR_W = 8
) (
   // Clock and reset
   input  wire logic              ref_clk,
   input  wire logic              rst_n,
   // AXI4-Lite write
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // AXI4-Lite read
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // Source clock pins: 0 loop oscillator, 1 internal ref, 2 external ref
   input  wire logic [2:0]        srcClkIn,
   input  wire logic              oscReadyIn,
   // System requests
   input  wire logic              stopReq,
   input  wire logic              debugActive,
   // Clock and control outputs
   output var fcs_pkg::fcsClkOut_s  clkOut,
   output var fcs_pkg::fcsOscCtrl_s oscCtrl,
   output logic [8:0]             intRefTrim,
   output logic                   loopEnable,
   output logic                   loopRefIsInternal,
   output logic                   loopRefTick
);

   // ****************************************
   // Declarations
   // ****************************************
   logic [7:0]       ctrl1_r;
   logic [7:0]       ctrl2_r;
   logic [7:0]       trim_r;
   logic             fineTrim_r;
   logic             bvalid_r;
   logic [1:0]       bresp_r;
   logic             rvalid_r;
   logic [1:0]       rresp_r;
   logic [31:0]      rdata_r;
   logic [2:0]       clkSync1_r;
   logic [2:0]       clkSync2_r;
   logic [2:0]       clkPrev_r;
   logic [2:0]       srcEdge;
   logic             oscSync1_r;
   logic             oscReady_r;
   logic             refSync1_r;
   logic             refStatus_r;
   fcs_pkg::fcsMode_e mode_r;
   fcs_pkg::fcsMode_e modeNxt;
   logic             prevIntMode_r;
   logic             prevExtMode_r;
   logic [1:0]       activeSrc_r;
   logic [1:0]       srcStatus_r;
   logic             awaitEdge_r;
   logic [2:0]       divCnt_r;
   logic [6:0]       refCnt_r;
   logic             modTick_r;
   logic             busClk_r;
   logic             dbgClk_r;
   logic             intRefOut_r;
   logic             extRefOut_r;
   logic             refTick_r;

   // ****************************************
   // Register fields
   // ****************************************
   wire [1:0] srcSel    = ctrl1_r[fcs_pkg::C1_SRC_HI:fcs_pkg::C1_SRC_LO];
   wire [2:0] refDiv    = ctrl1_r[fcs_pkg::C1_REF_DIVIDER_HI:fcs_pkg::C1_REF_DIVIDER_LO];
   wire       refSelReq = ctrl1_r[fcs_pkg::C1_REFSEL];
   wire       irOutEn   = ctrl1_r[fcs_pkg::C1_IROUT];
   wire       irStopEn  = ctrl1_r[fcs_pkg::C1_IRSTOP];
   wire [1:0] busDiv    = ctrl2_r[fcs_pkg::C2_BUS_DIVIDER_HI:fcs_pkg::C2_BUS_DIVIDER_LO];
   wire       erOutEn   = ctrl2_r[fcs_pkg::C2_EROUT];
   wire       erStopEn  = ctrl2_r[fcs_pkg::C2_ERSTOP];

   // ****************************************
   // Bus decode
   // ****************************************
   wire       wrTake   = s_axi_awvalid & s_axi_wvalid & ~bvalid_r;
   wire       wrHit    = (s_axi_awaddr[ADDR_W-1:4] == '0) & (s_axi_awaddr[1:0] == 2'h0);
   wire [3:0] wrOfs    = {s_axi_awaddr[3:2], 2'h0};
   wire       wrByte   = wrTake & wrHit & s_axi_wstrb[0];
   wire [7:0] wrData   = s_axi_wdata[7:0];
   wire       rdTake   = s_axi_arvalid & ~rvalid_r;
   wire       rdHit    = (s_axi_araddr[ADDR_W-1:4] == '0) & (s_axi_araddr[1:0] == 2'h0);
   wire [3:0] rdOfs    = {s_axi_araddr[3:2], 2'h0};
   wire [7:0] statByte = {3'h0, refStatus_r, srcStatus_r, oscReady_r, fineTrim_r};
   wire [7:0] rdByte   = (rdOfs == fcs_pkg::OFS_CTRL1) ? ctrl1_r :
                         (rdOfs == fcs_pkg::OFS_CTRL2) ? ctrl2_r :
                         (rdOfs == fcs_pkg::OFS_TRIM)  ? trim_r  : statByte;

   assign s_axi_awready = wrTake;
   assign s_axi_wready  = wrTake;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_arready = rdTake;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rresp   = rresp_r;
   assign s_axi_rdata   = rdata_r;

   // ****************************************
   // Bus responses
   // ****************************************
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         bvalid_r <= 1'b0;
         bresp_r  <= fcs_pkg::RESP_OKAY;
      end
      else if (wrTake)
      begin
         bvalid_r <= 1'b1;
         bresp_r  <= wrHit ? fcs_pkg::RESP_OKAY : fcs_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
         bvalid_r <= 1'b0;
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         rvalid_r <= 1'b0;
         rresp_r  <= fcs_pkg::RESP_OKAY;
         rdata_r  <= 32'h0000_0000;
      end
      else if (rdTake)
      begin
         rvalid_r <= 1'b1;
         rresp_r  <= rdHit ? fcs_pkg::RESP_OKAY : fcs_pkg::RESP_SLVERR;
         rdata_r  <= rdHit ? {24'h00_0000, rdByte} : 32'h0000_0000;
      end
      else if (s_axi_rready)
         rvalid_r <= 1'b0;
   end

   // ****************************************
   // Register file
   // ****************************************
   // Only the fine trim bit of the status register is writable
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         ctrl1_r    <= fcs_pkg::RST_CTRL1;
         ctrl2_r    <= fcs_pkg::RST_CTRL2;
         trim_r     <= fcs_pkg::RST_TRIM;
         fineTrim_r <= fcs_pkg::RST_FINE_TRIM_BIT;
      end
      else if (wrByte)
      begin
         if (wrOfs == fcs_pkg::OFS_CTRL1)
            ctrl1_r <= wrData;
         if (wrOfs == fcs_pkg::OFS_CTRL2)
            ctrl2_r <= wrData;
         if (wrOfs == fcs_pkg::OFS_TRIM)
            trim_r <= wrData;
         if (wrOfs == fcs_pkg::OFS_STAT)
            fineTrim_r <= wrData[fcs_pkg::ST_FINE_TRIM_BIT];
      end
   end

   assign intRefTrim = {trim_r, fineTrim_r};

   // ****************************************
   // Pin synchronisers and edge detect
   // ****************************************
   // The source clocks are far slower than ref_clk and are seen as levels
   for (genvar gi = 0; gi < 3; gi++)
   begin : g_clkSync
      always_ff @(posedge ref_clk)
      begin
         if (!rst_n)
         begin
            clkSync1_r[gi] <= 1'b0;
            clkSync2_r[gi] <= 1'b0;
            clkPrev_r[gi]  <= 1'b0;
         end
         else
         begin
            clkSync1_r[gi] <= srcClkIn[gi];
            clkSync2_r[gi] <= clkSync1_r[gi];
            clkPrev_r[gi]  <= clkSync2_r[gi];
         end
      end
      assign srcEdge[gi] = clkSync2_r[gi] & ~clkPrev_r[gi];
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         oscSync1_r  <= 1'b0;
         oscReady_r  <= 1'b0;
         refSync1_r  <= fcs_pkg::RST_REFST;
         refStatus_r <= fcs_pkg::RST_REFST;
      end
      else
      begin
         oscSync1_r  <= oscReadyIn;
         oscReady_r  <= oscSync1_r;
         refSync1_r  <= refSelReq;
         refStatus_r <= refSync1_r;
      end
   end

   // ****************************************
   // Mode sequencing
   // ****************************************
   wire [1:0] reqSrc   = (srcSel == fcs_pkg::SRC_RSV) ? fcs_pkg::SRC_LOOP : srcSel;
   wire       lpBypass = ctrl2_r[fcs_pkg::C2_LP] & ~debugActive;
   wire       running  = (mode_r != fcs_pkg::STOP_MODE);
   wire       intMode  = (mode_r == fcs_pkg::ENGAGED_INTERNAL) |
                         (mode_r == fcs_pkg::BYPASSED_INTERNAL) |
                         (mode_r == fcs_pkg::BYPASSED_INTERNAL_LOWPW);
   wire       extMode  = (mode_r == fcs_pkg::ENGAGED_EXTERNAL) |
                         (mode_r == fcs_pkg::BYPASSED_EXTERNAL) |
                         (mode_r == fcs_pkg::BYPASSED_EXTERNAL_LOWPW);
   wire       loopOn   = running & (mode_r != fcs_pkg::BYPASSED_INTERNAL_LOWPW) &
                         (mode_r != fcs_pkg::BYPASSED_EXTERNAL_LOWPW);

   always_comb
   begin
      modeNxt = fcs_pkg::ENGAGED_INTERNAL;
      if (stopReq)
         modeNxt = fcs_pkg::STOP_MODE;
      else
         case (reqSrc)
            fcs_pkg::SRC_INT:
               modeNxt = lpBypass ? fcs_pkg::BYPASSED_INTERNAL_LOWPW
                                  : fcs_pkg::BYPASSED_INTERNAL;
            fcs_pkg::SRC_EXT:
               modeNxt = lpBypass ? fcs_pkg::BYPASSED_EXTERNAL_LOWPW
                                  : fcs_pkg::BYPASSED_EXTERNAL;
            default:
               modeNxt = refStatus_r ? fcs_pkg::ENGAGED_INTERNAL
                                     : fcs_pkg::ENGAGED_EXTERNAL;
         endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         mode_r        <= fcs_pkg::ENGAGED_INTERNAL;
         prevIntMode_r <= 1'b1;
         prevExtMode_r <= 1'b0;
      end
      else
      begin
         mode_r <= modeNxt;
         if (running)
         begin
            prevIntMode_r <= intMode;
            prevExtMode_r <= extMode;
         end
      end
   end

   // ****************************************
   // Source switching and bus divider
   // ****************************************
   // Switch only on a divider boundary so no short output period appears;
   // a dead old source caught mid-count holds off the switch until it ticks again
   wire [2:0] divMask = (busDiv == 2'h0) ? 3'h0 :
                        (busDiv == 2'h1) ? 3'h1 :
                        (busDiv == 2'h2) ? 3'h3 : 3'h7;
   wire       selEdge = (activeSrc_r == fcs_pkg::SRC_INT) ? srcEdge[1] :
                        (activeSrc_r == fcs_pkg::SRC_EXT) ? srcEdge[2] : srcEdge[0];
   wire       doSwitch = running & (reqSrc != activeSrc_r) & (divCnt_r == 3'h0);
   wire       tickNow  = running & selEdge & (divCnt_r >= divMask);

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         activeSrc_r <= fcs_pkg::SRC_LOOP;
         srcStatus_r <= fcs_pkg::SRC_LOOP;
         awaitEdge_r <= 1'b0;
      end
      else if (doSwitch)
      begin
         activeSrc_r <= reqSrc;
         awaitEdge_r <= 1'b1;
      end
      else if (awaitEdge_r & selEdge)
      begin
         srcStatus_r <= activeSrc_r;
         awaitEdge_r <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         divCnt_r <= 3'h0;
      else if (doSwitch | tickNow)
         divCnt_r <= 3'h0;
      else if (running & selEdge)
         divCnt_r <= divCnt_r + 3'h1;
   end

   // ****************************************
   // Reference divider for the loop
   // ****************************************
   wire [6:0] refMask = 7'h7F >> (3'h7 - refDiv);
   wire       refEdge = refStatus_r ? srcEdge[1] : srcEdge[2];
   wire       refTickNow = loopOn & refEdge & (refCnt_r >= refMask);

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         refCnt_r <= 7'h00;
      else if (!loopOn | refTickNow)
         refCnt_r <= 7'h00;
      else if (refEdge)
         refCnt_r <= refCnt_r + 7'h01;
   end

   // ****************************************
   // Clock outputs
   // ****************************************
   wire irRun = running ? 1'b1 : (irStopEn & (irOutEn | prevIntMode_r));
   wire erRun = running ? 1'b1 : (erStopEn & (erOutEn | prevExtMode_r));

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         modTick_r   <= 1'b0;
         busClk_r    <= 1'b0;
         dbgClk_r    <= 1'b0;
         intRefOut_r <= 1'b0;
         extRefOut_r <= 1'b0;
         refTick_r   <= 1'b0;
      end
      else
      begin
         modTick_r   <= tickNow;
         busClk_r    <= running & (busClk_r ^ modTick_r);
         dbgClk_r    <= loopOn & (dbgClk_r ^ srcEdge[0]);
         intRefOut_r <= irOutEn & irRun & clkSync2_r[1];
         extRefOut_r <= erOutEn & erRun & clkSync2_r[2];
         refTick_r   <= refTickNow;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         oscCtrl <= '0;
      else
      begin
         oscCtrl.highGain      <= ctrl2_r[fcs_pkg::C2_HGO];
         oscCtrl.freqRange     <= ctrl2_r[fcs_pkg::C2_RANGE];
         oscCtrl.requestOsc    <= ctrl2_r[fcs_pkg::C2_OSCREQ];
         oscCtrl.refEnable     <= erOutEn & erRun;
         oscCtrl.refStopEnable <= erStopEn;
      end
   end

   assign clkOut.moduleOutTick = modTick_r;
   assign clkOut.busClk        = busClk_r;
   assign clkOut.debugClk      = dbgClk_r;
   assign clkOut.intRefClkOut  = intRefOut_r;
   assign clkOut.extRefClkOut  = extRefOut_r;
   assign loopEnable           = loopOn;
   assign loopRefIsInternal    = refStatus_r;
   assign loopRefTick          = refTick_r;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   reset_mode_a: assert property ($past(!rst_n) |-> mode_r == fcs_pkg::ENGAGED_INTERNAL)
      else $error("mode after reset is not engaged internal");

   debug_gate_a: assert property (!loopOn |=> !dbgClk_r)
      else $error("debug clock runs without the loop");

   debug_half_a: assert property (loopOn && srcEdge[0] && $past(loopOn) |=>
                                  dbgClk_r != $past(dbgClk_r))
      else $error("debug clock missed a loop edge");

   stop_noclk_a: assert property (mode_r == fcs_pkg::STOP_MODE |=> !modTick_r)
      else $error("module clock ticks in stop");

   bus_half_a: assert property (modTick_r && running |=> busClk_r != $past(busClk_r))
      else $error("bus clock did not toggle on module tick");

   bus_divide_a: assert property (modTick_r |-> $past(divCnt_r) >= $past(divMask))
      else $error("module tick before divider count reached");

   src_reserved_a: assert property (activeSrc_r != fcs_pkg::SRC_RSV)
      else $error("reserved source code became active");

   ref_sync_a: assert property ($changed(refSelReq) |=> refStatus_r == $past(refStatus_r))
      else $error("reference status followed select without delay");

   src_status_a: assert property ($changed(srcStatus_r) |->
                                  srcStatus_r == activeSrc_r && $past(selEdge))
      else $error("source status changed before the new source drove");

   cover_lowpower_c: cover property (mode_r == fcs_pkg::BYPASSED_EXTERNAL_LOWPW);
   cover_stop_c:     cover property (mode_r == fcs_pkg::STOP_MODE ##1 running);
   cover_switch_c:   cover property (doSwitch ##[1:40] $changed(srcStatus_r));

endmodule : fcs_clock_source

`default_nettype wire

// [verilog/fcs_pkg.sv]
// Package: register map, field layout, modes and carriers of the clock source selector
package fcs_pkg;

   // ****************************************
   // Register byte offsets
   // ****************************************
   localparam logic [3:0] OFS_CTRL1 = 4'h0;
   localparam logic [3:0] OFS_CTRL2 = 4'h4;
   localparam logic [3:0] OFS_TRIM  = 4'h8;
   localparam logic [3:0] OFS_STAT  = 4'hC;

   // ****************************************
   // Values after reset
   // ****************************************
   localparam logic [7:0] RST_CTRL1  = 8'h04;
   localparam logic [7:0] RST_CTRL2  = 8'h40;
   localparam logic [7:0] RST_TRIM   = 8'h80;
   localparam logic       RST_FINE_TRIM_BIT  = 1'h0;
   localparam logic       RST_REFST  = 1'h1;

   // ****************************************
   // Field positions
   // ****************************************
   // clock_control_one
   localparam int C1_SRC_HI  = 7;
   localparam int C1_SRC_LO  = 6;
   localparam int C1_REF_DIVIDER_HI = 5;
   localparam int C1_REF_DIVIDER_LO = 3;
   localparam int C1_REFSEL  = 2;
   localparam int C1_IROUT   = 1;
   localparam int C1_IRSTOP  = 0;
   // clock_control_two
   localparam int C2_BUS_DIVIDER_HI = 7;
   localparam int C2_BUS_DIVIDER_LO = 6;
   localparam int C2_RANGE   = 5;
   localparam int C2_HGO     = 4;
   localparam int C2_LP      = 3;
   localparam int C2_OSCREQ  = 2;
   localparam int C2_EROUT   = 1;
   localparam int C2_ERSTOP  = 0;
   // clock_status_control
   localparam int ST_FINE_TRIM_BIT   = 0;

   // ****************************************
   // Source codes and bus answers
   // ****************************************
   localparam logic [1:0] SRC_LOOP    = 2'h0;
   localparam logic [1:0] SRC_INT     = 2'h1;
   localparam logic [1:0] SRC_EXT     = 2'h2;
   localparam logic [1:0] SRC_RSV     = 2'h3;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [2:0] {
      ENGAGED_INTERNAL        = 3'b000,
      ENGAGED_EXTERNAL        = 3'b001,
      BYPASSED_INTERNAL       = 3'b010,
      BYPASSED_INTERNAL_LOWPW = 3'b011,
      BYPASSED_EXTERNAL       = 3'b100,
      BYPASSED_EXTERNAL_LOWPW = 3'b101,
      STOP_MODE               = 3'b110
   } fcsMode_e;

   typedef struct packed {
      logic highGain;
      logic freqRange;
      logic requestOsc;
      logic refEnable;
      logic refStopEnable;
   } fcsOscCtrl_s;

   typedef struct packed {
      logic moduleOutTick;
      logic busClk;
      logic debugClk;
      logic intRefClkOut;
      logic extRefClkOut;
   } fcsClkOut_s;

endpackage : fcs_pkg

// [sim/fcs_src_model.sv]
// Source clock pins and oscillator ready flag seen by the selector
`timescale 1ns/1ps
`default_nettype none
module fcs_src_model (
   // Clock
   input  wire logic       ref_clk,
   // Pins
   output logic [2:0]      srcClk,
   output logic            oscReady
);
   int cnt = 0;
   // Off-edge changes so each pin is seen with a fixed sync delay
   always @(negedge ref_clk) cnt <= cnt + 1;
   // Periods 8, 12 and 20 cycles, kept well below the reference limit
   assign srcClk   = {(cnt % 20) < 10, (cnt % 12) < 6, (cnt % 8) < 4};
   // Crystal reports ready only after a start-up delay
   assign oscReady = cnt > 40;
endmodule : fcs_src_model
`default_nettype wire

// [sim/test_fll_clock_source_selector.sv]
// Self-checking bench for the clock source selector
`timescale 1ns/1ps
`default_nettype none
module test_fll_clock_source_selector;
   logic        ref_clk = 0, rst_n = 0, stopReq = 0, dbgAct = 0;
   logic [7:0]  awAddr = 0, arAddr = 0;
   logic [31:0] wData = 0, rData;
   logic        awValid = 0, wValid = 0, bReady = 0, arValid = 0, rReady = 0;
   logic        awReady, wReady, bValid, arReady, rValid, oscRdy, loopEn, refInt, refTick;
   logic [1:0]  bResp, rResp;
   logic [2:0]  srcClk;
   logic [8:0]  trim;
   logic [33:0] expQ[$];
   fcs_pkg::fcsClkOut_s  clkOut;
   fcs_pkg::fcsOscCtrl_s oscCtrl;
   int miscompares = 0, check_count = 0, cyc = 0;
   fcs_clock_source fcs_clock_source_inst (.ref_clk(ref_clk), .rst_n(rst_n),
      .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
      .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
      .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
      .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
      .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
      .srcClkIn(srcClk), .oscReadyIn(oscRdy), .stopReq(stopReq), .debugActive(dbgAct),
      .clkOut(clkOut), .oscCtrl(oscCtrl), .intRefTrim(trim), .loopEnable(loopEn),
      .loopRefIsInternal(refInt), .loopRefTick(refTick));
   fcs_src_model fcs_src_model_inst (.ref_clk(ref_clk), .srcClk(srcClk), .oscReady(oscRdy));
   initial forever #4 ref_clk = ~ref_clk;
   always @(posedge ref_clk) cyc <= cyc + 1;
   // ****************************************
   // Checking and bus tasks
   // ****************************************
   task automatic check(input logic [33:0] seen, input logic [33:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("FAIL %0t: got %h want %h", $time, seen, exp);
      end
   endtask : check
   task automatic stop_test();
      if (miscompares == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : stop_test
   function automatic logic sig(input int k);
      case (k)
         0: return awReady;
         1: return bValid;
         2: return arReady;
         3: return rValid;
         5: return refTick;
         default: return clkOut.moduleOutTick;
      endcase
   endfunction : sig
   // Bounded wait for an edge at which the chosen signal is high
   task automatic waitFor(input int k, input int lim);
      int i;
      i = 0;
      do
      begin
         @(posedge ref_clk);
         i++;
      end
      while (sig(k) !== 1'b1 && i < lim);
      if (i >= lim)
      begin
         miscompares++;
         stop_test();
      end
   endtask : waitFor
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
      awAddr <= a;
      wData <= {24'h0, d};
      awValid <= 1;
      wValid <= 1;
      bReady <= 1;
      waitFor(0, 50);
      awValid <= 0;
      wValid <= 0;
      waitFor(1, 50);
      bReady <= 0;
      check(bResp, er);
      @(posedge ref_clk);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [33:0] exp);
      expQ.push_back(exp);
      arAddr <= a;
      arValid <= 1;
      rReady <= 1;
      waitFor(2, 50);
      arValid <= 0;
      waitFor(3, 50);
      rReady <= 0;
      @(posedge ref_clk);
   endtask : rd
   // Oldest noted read result against the answer on the bus
   always @(posedge ref_clk)
      if (rValid === 1'b1 && rReady === 1'b1 && expQ.size() > 0)
         check({rResp, rData}, expQ.pop_front());
   // Cycles between two ticks of the chosen output and whether the bus clock toggled
   task automatic gap(input int k, output int g, output logic t);
      int c;
      logic b;
      waitFor(k, 400);
      c = cyc;
      b = clkOut.busClk;
      waitFor(k, 400);
      g = cyc - c;
      t = b ^ clkOut.busClk;
   endtask : gap
   // ****************************************
   // Scenarios
   // ****************************************
   initial
   begin
      int g, per[4];
      logic tg;
      logic [7:0] r, n;
      per = '{8, 12, 20, 8};
      void'($urandom(78));
      repeat (3) @(posedge ref_clk);
      rst_n <= 1;
      rd(fcs_pkg::OFS_STAT, 34'h10);
      rd(fcs_pkg::OFS_CTRL1, 34'h04);
      rd(fcs_pkg::OFS_CTRL2, 34'h40);
      rd(8'h10, {fcs_pkg::RESP_SLVERR, 32'h0});
      wr(8'h13, 8'h55, fcs_pkg::RESP_SLVERR);
      r = 8'($urandom);
      wr(fcs_pkg::OFS_TRIM, r, fcs_pkg::RESP_OKAY);
      wr(fcs_pkg::OFS_STAT, 8'hFF, fcs_pkg::RESP_OKAY);
      rd(fcs_pkg::OFS_TRIM, {26'h0, r});
      check(trim, {r, 1'b1});
      wr(fcs_pkg::OFS_CTRL2, 8'h3F, fcs_pkg::RESP_OKAY);
      check(oscCtrl, 5'h1F);
      for (int s = 0; s < 4; s++)
         for (int d = 0; d < 4; d++)
         begin
            wr(fcs_pkg::OFS_CTRL1, {2'(s), 6'h04}, fcs_pkg::RESP_OKAY);
            // Odd divider codes also ask for low-power bypass
            wr(fcs_pkg::OFS_CTRL2, {2'(d), 2'b00, 1'(d), 3'h0}, fcs_pkg::RESP_OKAY);
            // Early ticks may still belong to the old source
            repeat (3) gap(4, g, tg);
            check(g, per[s] << d);
            check(loopEn, (d % 2 == 1 && (s == 1 || s == 2)) ? 1'b0 : 1'b1);
            check(tg, 1'b1);
            rd(fcs_pkg::OFS_STAT, {28'h1, (s == 3) ? 2'b00 : 2'(s), 2'b11});
         end
      wr(fcs_pkg::OFS_CTRL1, 8'h00, fcs_pkg::RESP_OKAY);
      repeat (3) @(posedge ref_clk);
      check({refInt, loopEn}, 2'b01);
      rd(fcs_pkg::OFS_STAT, 34'h03);
      // Random reference divider 1..8 on the external reference
      n = 8'($urandom) & 8'h18;
      wr(fcs_pkg::OFS_CTRL1, n, fcs_pkg::RESP_OKAY);
      repeat (2) gap(5, g, tg);
      check(g, 20 << n[4:3]);
      wr(fcs_pkg::OFS_CTRL1, 8'h44, fcs_pkg::RESP_OKAY);
      wr(fcs_pkg::OFS_CTRL2, 8'h08, fcs_pkg::RESP_OKAY);
      repeat (3) @(posedge ref_clk);
      check({loopEn, clkOut.debugClk}, 2'b00);
      dbgAct <= 1;
      repeat (3) @(posedge ref_clk);
      check(loopEn, 1'b1);
      // Internal reference stop enable stays clear, so no regulator hold is owed
      stopReq <= 1;
      repeat (4) @(posedge ref_clk);
      n = 0;
      repeat (100)
      begin
         @(posedge ref_clk);
         n = n + clkOut.moduleOutTick + clkOut.intRefClkOut + clkOut.debugClk;
         n = n + clkOut.extRefClkOut + clkOut.busClk;
      end
      check({n, loopEn}, 9'h0);
      stopReq <= 0;
      dbgAct <= 0;
      stop_test();
   end
endmodule : test_fll_clock_source_selector
`default_nettype wire
